/* File: esf_cfg.svh */
// Functional notes
// - Capture differential sense at host-programmed instant within each switching period.
// - Error equals 10-bit reference DAC set-point minus captured sense.
// - Gain codes 0..3 select front-end gains 1, 2, 4, 8.
// - Gain fixes step and range: 8 mV/-256..248 down to 1 mV/-32..31.
// - Digitize amplified error; result feeds compensator downstream.
// - Front-end gain stored among compensator gain coefficients written by host.
// - Separate gain sets for ramp/tracking, regulation, light load.
// - Overrange reports clamped -32 or 31 LSBs.
// - While saturated, move reference DAC toward restoring error range.
// - Saturation slew rate 0.156 V/ms at differential inputs.
// - Nominal set-point from VOUT_COMMAND, VOUT_CAL_OFFSET, VOUT_MAX.
// - Hold separate margin-high and margin-low set-points.
// - OPERATION selects nominal, margin-high or margin-low target.
// - OPERATION option suppresses voltage faults while margined.
// - Bank 0 ramp, bank 1 regulation, bank 2 below light-load threshold.
`ifndef ESF_CFG_SVH
`define ESF_CFG_SVH
`define ESF_OFF_VOUT_CMD 4'h0
`define ESF_OFF_CAL_OFF 4'h1
`define ESF_OFF_VOUT_MAX 4'h2
`define ESF_OFF_MARGIN_HI 4'h3
`define ESF_OFF_MARGIN_LO 4'h4
`define ESF_OFF_OPERATION 4'h5
`define ESF_OFF_SAMPLE_AT 4'h6
`define ESF_OFF_PERIOD 4'h7
`define ESF_OFF_GAIN_B0 4'h8
`define ESF_OFF_GAIN_B1 4'h9
`define ESF_OFF_GAIN_B2 4'ha
`define ESF_OFF_LIGHT_THR 4'hb
`define ESF_OFF_STATUS 4'hc
`define ESF_OFF_DAC 4'hd
`define ESF_RST_VOUT_MAX 10'h3ff
`define ESF_RST_PERIOD 16'h0064
`define ESF_RST_SAMPLE_AT 16'h0032
`define ESF_RST_LIGHT_THR 16'h0000
`define ESF_OP_MARGIN_HI_BIT 5
`define ESF_OP_MARGIN_LO_BIT 4
`define ESF_OP_SUPPRESS_BIT 2
`define ESF_DAC_W 10
`define ESF_GAIN_W 2
`define ESF_CODE_W 6
`define ESF_CODE_MAX 31
`define ESF_CODE_MIN -32
`define ESF_ADC_SHIFT 3
`define ESF_CLK_PERIOD_NS 10
`define ESF_DAC_LSB_UV 1000
`define ESF_SLEW_MV_PER_MS 156
`define ESF_NS_PER_MS 1000000
`define ESF_UV_PER_MV 1000
`endif

/* File: esf_pkg.sv */
package esf_pkg;
	typedef enum logic [2:0] {
		ESF_BANK_RAMP = 3'b001,
		ESF_BANK_REG = 3'b010,
		ESF_BANK_LIGHT = 3'b100
	} esf_bank_e;
endpackage

/* File: esf_fifo.sv */
`timescale 1ns/100ps
module esf_fifo
#(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
)
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_ptr_q;
	logic [AW-1:0] rd_ptr_q;
	logic [AW:0] count_q;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;

	assign in_ready = count_q != (AW+1)'(DEPTH);
	assign out_valid = count_q != '0;
	assign out_data = mem_q[rd_ptr_q];

	always_ff @(posedge core_clk)
	begin
		if (push)
			mem_q[wr_ptr_q] <= in_data;
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q <= '0;
		end
		else
		begin
			if (push)
				wr_ptr_q <= (wr_ptr_q == AW'(DEPTH-1)) ? '0 : wr_ptr_q + 1'b1;
			if (pop)
				rd_ptr_q <= (rd_ptr_q == AW'(DEPTH-1)) ? '0 : rd_ptr_q + 1'b1;
			count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule // esf_fifo

/* File: esf_front_end.sv */
// Chosen here: the register offsets and the plain strobed port.
`timescale 1ns/100ps
`include "esf_cfg.svh"
module esf_front_end
	import esf_pkg::*;
#(
	parameter int SENSE_W = 12,
	parameter int FIFO_DEPTH = 4
)
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	input wire logic [SENSE_W-1:0] sense_positive_input,
	input wire logic [SENSE_W-1:0] sense_negative_input,
	input wire logic ramp_active,
	input wire logic [15:0] out_current,
	output logic [`ESF_DAC_W-1:0] ref_dac_code,
	output logic error_valid,
	input wire logic error_ready,
	output logic [`ESF_CODE_W-1:0] error_code,
	output logic [1:0] error_bank,
	output logic error_saturated,
	output logic fault_suppress
);
	localparam int DW = `ESF_DAC_W;
	localparam int ERR_W = SENSE_W + 2;
	localparam int SC_W = ERR_W + 3;
	localparam int FW = `ESF_CODE_W + 2;
	// Time for one DAC code at the recovery slew rate, in ns
	localparam int SLEW_STEP_NS = (`ESF_DAC_LSB_UV * `ESF_NS_PER_MS) / (`ESF_SLEW_MV_PER_MS * `ESF_UV_PER_MV);
	localparam int SLEW_CYC = (SLEW_STEP_NS / `ESF_CLK_PERIOD_NS < 1) ? 1 : SLEW_STEP_NS / `ESF_CLK_PERIOD_NS;
	localparam logic signed [SC_W-1:0] CODE_MAX = SC_W'(`ESF_CODE_MAX);
	localparam logic signed [SC_W-1:0] CODE_MIN = SC_W'(`ESF_CODE_MIN);

	//--------------------------------------------------
	// Host registers
	//--------------------------------------------------
	logic [DW-1:0] vout_cmd_q;
	logic signed [DW-1:0] cal_off_q;
	logic [DW-1:0] vout_max_q;
	logic [DW-1:0] margin_hi_q;
	logic [DW-1:0] margin_lo_q;
	logic [7:0] operation_q;
	logic [15:0] sample_at_q;
	logic [15:0] period_q;
	logic [`ESF_GAIN_W-1:0] gain_q [3];
	logic [15:0] light_thr_q;
	logic [15:0] rdata_q;

	wire wr_cmd = reg_wr && reg_addr == `ESF_OFF_VOUT_CMD;
	wire wr_cal = reg_wr && reg_addr == `ESF_OFF_CAL_OFF;
	wire wr_max = reg_wr && reg_addr == `ESF_OFF_VOUT_MAX;
	wire wr_mhi = reg_wr && reg_addr == `ESF_OFF_MARGIN_HI;
	wire wr_mlo = reg_wr && reg_addr == `ESF_OFF_MARGIN_LO;
	wire wr_op = reg_wr && reg_addr == `ESF_OFF_OPERATION;
	wire wr_at = reg_wr && reg_addr == `ESF_OFF_SAMPLE_AT;
	wire wr_per = reg_wr && reg_addr == `ESF_OFF_PERIOD;
	wire wr_thr = reg_wr && reg_addr == `ESF_OFF_LIGHT_THR;
	wire [2:0] wr_gain = {reg_wr && reg_addr == `ESF_OFF_GAIN_B2,
		reg_wr && reg_addr == `ESF_OFF_GAIN_B1,
		reg_wr && reg_addr == `ESF_OFF_GAIN_B0};

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			vout_cmd_q <= '0;
			cal_off_q <= '0;
			vout_max_q <= `ESF_RST_VOUT_MAX;
			margin_hi_q <= '0;
			margin_lo_q <= '0;
			operation_q <= '0;
			sample_at_q <= `ESF_RST_SAMPLE_AT;
			period_q <= `ESF_RST_PERIOD;
			light_thr_q <= `ESF_RST_LIGHT_THR;
		end
		else
		begin
			if (wr_cmd) vout_cmd_q <= reg_wdata[DW-1:0];
			if (wr_cal) cal_off_q <= reg_wdata[DW-1:0];
			if (wr_max) vout_max_q <= reg_wdata[DW-1:0];
			if (wr_mhi) margin_hi_q <= reg_wdata[DW-1:0];
			if (wr_mlo) margin_lo_q <= reg_wdata[DW-1:0];
			if (wr_op) operation_q <= reg_wdata[7:0];
			if (wr_at) sample_at_q <= reg_wdata;
			if (wr_per) period_q <= reg_wdata;
			if (wr_thr) light_thr_q <= reg_wdata;
		end
	end

	// One gain coefficient per bank
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++)
		begin : g_gain
			always_ff @(posedge core_clk)
			begin
				if (rst)
					gain_q[gi] <= '0;
				else if (wr_gain[gi])
					gain_q[gi] <= reg_wdata[`ESF_GAIN_W-1:0];
			end
		end
	endgenerate

	//--------------------------------------------------
	// Set-point selection
	//--------------------------------------------------
	logic signed [DW+1:0] nom_sum_w;
	logic [DW-1:0] nom_pos_w;
	logic [DW-1:0] nominal_w;
	logic [DW-1:0] target_w;
	logic [DW-1:0] target_q;
	assign nom_sum_w = $signed({2'b00, vout_cmd_q}) + (DW+2)'(cal_off_q);
	assign nom_pos_w = nom_sum_w[DW+1] ? '0 : (nom_sum_w[DW] ? '1 : nom_sum_w[DW-1:0]);
	assign nominal_w = (nom_pos_w > vout_max_q) ? vout_max_q : nom_pos_w;
	wire sel_hi = operation_q[`ESF_OP_MARGIN_HI_BIT] && !operation_q[`ESF_OP_MARGIN_LO_BIT];
	wire sel_lo = operation_q[`ESF_OP_MARGIN_LO_BIT] && !operation_q[`ESF_OP_MARGIN_HI_BIT];
	assign target_w = sel_hi ? margin_hi_q : (sel_lo ? margin_lo_q : nominal_w);
	assign fault_suppress = (sel_hi || sel_lo) && operation_q[`ESF_OP_SUPPRESS_BIT];
	wire tgt_chg = target_w != target_q;

	//--------------------------------------------------
	// Coefficient bank
	//--------------------------------------------------
	esf_bank_e bank_w;
	logic [1:0] bank_idx_w;
	assign bank_w = ramp_active ? ESF_BANK_RAMP :
		((out_current < light_thr_q) ? ESF_BANK_LIGHT : ESF_BANK_REG);
	assign bank_idx_w = (bank_w == ESF_BANK_RAMP) ? 2'h0 : ((bank_w == ESF_BANK_LIGHT) ? 2'h2 : 2'h1);
	wire [`ESF_GAIN_W-1:0] act_gain = gain_q[bank_idx_w];

	//--------------------------------------------------
	// Sense synchronisers and sample instant
	//--------------------------------------------------
	logic [SENSE_W-1:0] pos_s1_q;
	logic [SENSE_W-1:0] pos_s2_q;
	logic [SENSE_W-1:0] neg_s1_q;
	logic [SENSE_W-1:0] neg_s2_q;
	logic [15:0] per_cnt_q;
	logic signed [SENSE_W:0] diff_q;
	logic pend_q;
	wire samp_hit = per_cnt_q == sample_at_q;
	wire per_end = per_cnt_q >= period_q - 16'h0001;

	// Sense words are resampled every cycle; a code caught mid-change may mix two values
	always_ff @(posedge core_clk)
	begin
		pos_s1_q <= sense_positive_input;
		pos_s2_q <= pos_s1_q;
		neg_s1_q <= sense_negative_input;
		neg_s2_q <= neg_s1_q;
	end

	//--------------------------------------------------
	// Error conversion
	//--------------------------------------------------
	logic signed [ERR_W-1:0] err_w;
	logic signed [SC_W-1:0] err_sc_w;
	logic signed [SC_W-1:0] code_full_w;
	logic [`ESF_CODE_W-1:0] code_w;
	logic sat_pos_q;
	logic sat_neg_q;
	logic fifo_in_ready;
	assign err_w = $signed({{(ERR_W-DW){1'b0}}, ref_dac_code}) - ERR_W'(diff_q);
	assign err_sc_w = SC_W'(err_w) <<< act_gain;
	assign code_full_w = err_sc_w >>> `ESF_ADC_SHIFT;
	wire sat_pos_w = code_full_w > CODE_MAX;
	wire sat_neg_w = code_full_w < CODE_MIN;
	assign code_w = sat_pos_w ? `ESF_CODE_W'(`ESF_CODE_MAX) :
		(sat_neg_w ? `ESF_CODE_W'(`ESF_CODE_MIN) : code_full_w[`ESF_CODE_W-1:0]);
	wire push = pend_q && fifo_in_ready;

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			per_cnt_q <= '0;
			pend_q <= 1'b0;
			diff_q <= '0;
			sat_pos_q <= 1'b0;
			sat_neg_q <= 1'b0;
		end
		else
		begin
			per_cnt_q <= per_end ? '0 : per_cnt_q + 16'h0001;
			// A full FIFO stalls the pending conversion; later instants are skipped
			if (samp_hit && !pend_q)
			begin
				diff_q <= $signed({1'b0, pos_s2_q}) - $signed({1'b0, neg_s2_q});
				pend_q <= 1'b1;
			end
			else if (push)
				pend_q <= 1'b0;
			if (push)
			begin
				sat_pos_q <= sat_pos_w;
				sat_neg_q <= sat_neg_w;
			end
		end
	end

	//--------------------------------------------------
	// Reference DAC and saturation slew
	//--------------------------------------------------
	logic [DW-1:0] dac_q;
	logic [15:0] slew_cnt_q;
	wire sat_any = sat_pos_q || sat_neg_q;
	wire step = sat_any && slew_cnt_q == 16'(SLEW_CYC - 1);
	assign ref_dac_code = dac_q;
	assign error_saturated = sat_any;

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			dac_q <= '0;
			target_q <= '0;
			slew_cnt_q <= '0;
		end
		else
		begin
			target_q <= target_w;
			slew_cnt_q <= (!sat_any || step || tgt_chg) ? '0 : slew_cnt_q + 16'h0001;
			if (tgt_chg)
				dac_q <= target_w;
			else if (step && sat_pos_q && dac_q != '0)
				dac_q <= dac_q - 1'b1;
			else if (step && sat_neg_q && dac_q != '1)
				dac_q <= dac_q + 1'b1;
		end
	end

	//--------------------------------------------------
	// Output FIFO toward the compensator
	//--------------------------------------------------
	logic [FW-1:0] fifo_out;
	esf_fifo #(.WIDTH(FW), .DEPTH(FIFO_DEPTH)) u_fifo (
		.core_clk(core_clk),
		.rst(rst),
		.in_valid(pend_q),
		.in_ready(fifo_in_ready),
		.in_data({bank_idx_w, code_w}),
		.out_valid(error_valid),
		.out_ready(error_ready),
		.out_data(fifo_out)
	);
	assign error_code = fifo_out[`ESF_CODE_W-1:0];
	assign error_bank = fifo_out[FW-1:`ESF_CODE_W];

	//--------------------------------------------------
	// Register read-back
	//--------------------------------------------------
	logic [15:0] rd_mux_w;
	always_comb
	begin
		unique case (reg_addr)
			`ESF_OFF_VOUT_CMD: rd_mux_w = 16'(vout_cmd_q);
			`ESF_OFF_CAL_OFF: rd_mux_w = 16'($unsigned(cal_off_q));
			`ESF_OFF_VOUT_MAX: rd_mux_w = 16'(vout_max_q);
			`ESF_OFF_MARGIN_HI: rd_mux_w = 16'(margin_hi_q);
			`ESF_OFF_MARGIN_LO: rd_mux_w = 16'(margin_lo_q);
			`ESF_OFF_OPERATION: rd_mux_w = 16'(operation_q);
			`ESF_OFF_SAMPLE_AT: rd_mux_w = sample_at_q;
			`ESF_OFF_PERIOD: rd_mux_w = period_q;
			`ESF_OFF_GAIN_B0: rd_mux_w = 16'(gain_q[0]);
			`ESF_OFF_GAIN_B1: rd_mux_w = 16'(gain_q[1]);
			`ESF_OFF_GAIN_B2: rd_mux_w = 16'(gain_q[2]);
			`ESF_OFF_LIGHT_THR: rd_mux_w = light_thr_q;
			`ESF_OFF_STATUS: rd_mux_w = {9'h000, fault_suppress, pend_q, bank_w, sat_neg_q, sat_pos_q};
			`ESF_OFF_DAC: rd_mux_w = 16'(dac_q);
			default: rd_mux_w = 16'h0000;
		endcase
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
			rdata_q <= '0;
		else
			rdata_q <= reg_rd ? rd_mux_w : 16'h0000;
	end
	assign reg_rdata = rdata_q;

	//--------------------------------------------------
	// Slew monitor for the checks below
	//--------------------------------------------------
	logic [DW-1:0] dac_prev_q;
	logic [15:0] hold_cnt_q;
	wire dac_moved = dac_q != dac_prev_q;

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			dac_prev_q <= '0;
			hold_cnt_q <= '0;
		end
		else
		begin
			dac_prev_q <= dac_q;
			hold_cnt_q <= (!sat_any || dac_moved) ? '0 : hold_cnt_q + 16'h0001;
		end
	end

	//--------------------------------------------------
	// Assertions
	//--------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	sequence capture_s;
		samp_hit && !pend_q;
	endsequence
	sequence handoff_s;
		pend_q && fifo_in_ready ##1 !pend_q && error_valid;
	endsequence

	sample_capture_a: assert property (capture_s |=> pend_q
		&& diff_q == $signed({1'b0, $past(pos_s2_q)}) - $signed({1'b0, $past(neg_s2_q)}))
		else $error("sample not captured");
	period_wrap_a: assert property (per_end |=> per_cnt_q == '0) else $error("period counter did not wrap");
	error_form_a: assert property ($rose(pend_q) |-> err_w == $signed({{(ERR_W-DW){1'b0}}, ref_dac_code})
		- ($signed({1'b0, $past(pos_s2_q)}) - $signed({1'b0, $past(neg_s2_q)})))
		else $error("error not reference minus sense");
	gain_scale_a: assert property (pend_q && !sat_pos_w && !sat_neg_w && act_gain == 2'h3
		|-> $signed(code_w) == err_w) else $error("gain 8 code wrong");
	unity_step_a: assert property (pend_q && !sat_pos_w && !sat_neg_w && act_gain == 2'h0
		|-> $signed(code_w) == err_w >>> 3) else $error("gain 1 step wrong");
	conversion_push_a: assert property (capture_s ##1 fifo_in_ready |-> handoff_s)
		else $error("conversion not pushed");
	gain_store_a: assert property (wr_gain[1] |=> gain_q[1] == $past(reg_wdata[`ESF_GAIN_W-1:0]))
		else $error("gain not stored");
	bank_gain_a: assert property (ramp_active |-> bank_idx_w == 2'h0 && act_gain == gain_q[0])
		else $error("ramp bank not used");
	light_bank_a: assert property (!ramp_active && out_current < light_thr_q |-> bank_idx_w == 2'h2)
		else $error("light bank not used");
	clamp_pos_a: assert property (push && sat_pos_w |=> sat_pos_q ##0 $past(code_w) == 6'h1f)
		else $error("positive clamp wrong");
	clamp_neg_a: assert property (push && sat_neg_w |=> sat_neg_q ##0 $past(code_w) == 6'h20)
		else $error("negative clamp wrong");
	slew_dir_a: assert property (step && sat_pos_q && dac_q != '0 && !tgt_chg |=> dac_q == $past(dac_q) - 1'b1)
		else $error("slew direction wrong");
	slew_up_a: assert property (step && sat_neg_q && dac_q != '1 && !tgt_chg |=> dac_q == $past(dac_q) + 1'b1)
		else $error("upward slew wrong");
	slew_gap_a: assert property (step |=> !step [*8]) else $error("slew too fast");
	slew_rate_a: assert property (sat_any && dac_moved && !$past(tgt_chg) |-> hold_cnt_q >= 16'(SLEW_CYC - 1))
		else $error("reference slewed too fast");
	nominal_cap_a: assert property (nominal_w <= vout_max_q) else $error("nominal above maximum");
	margin_sel_a: assert property (sel_hi |=> target_q == $past(margin_hi_q))
		else $error("margin high not selected");
	margin_lo_a: assert property (sel_lo |=> target_q == $past(margin_lo_q))
		else $error("margin low not selected");
	suppress_a: assert property (fault_suppress |-> sel_hi || sel_lo) else $error("suppress outside margin");
endmodule // esf_front_end

/* File: esf_sense_model.sv */
`timescale 1ns/100ps
module esf_sense_model
(
	input wire logic core_clk,
	input wire logic [11:0] common_mv,
	input wire logic [11:0] diff_mv,
	output logic [11:0] pos_mv,
	output logic [11:0] neg_mv
);
	// Sense lines settle one clock after a new output level is requested
	always_ff @(posedge core_clk)
	begin
		pos_mv <= common_mv + diff_mv;
		neg_mv <= common_mv;
	end
endmodule // esf_sense_model

/* File: testbench.sv */
`timescale 1ns/100ps
`include "esf_cfg.svh"
module testbench;
	import esf_pkg::*;
	typedef struct packed {logic ramp; logic [15:0] cur; logic [11:0] diff; logic [5:0] code; logic [1:0] bank;} esf_row_s;
	typedef struct packed {logic [3:0] addr; logic [15:0] data; logic [9:0] dac; logic fs;} esf_wr_s;
	// ----------------------------------------
	// Expected results
	// ----------------------------------------
	localparam esf_row_s ROWS [8] = '{
		'{1'b0, 16'h00c8, 12'h100, 6'h00, 2'h1}, '{1'b0, 16'h00c8, 12'h0fb, 6'h05, 2'h1},
		'{1'b0, 16'h00c8, 12'h103, 6'h3d, 2'h1}, '{1'b1, 16'h00c8, 12'h0d8, 6'h05, 2'h0},
		'{1'b1, 16'h0032, 12'h128, 6'h3b, 2'h0}, '{1'b0, 16'h0032, 12'h0f6, 6'h02, 2'h2},
		'{1'b0, 16'h0032, 12'h10e, 6'h3c, 2'h2}, '{1'b0, 16'h00c8, 12'h0ff, 6'h01, 2'h1}};
	localparam esf_wr_s WRS [21] = '{
		'{`ESF_OFF_PERIOD, 16'h0014, 10'h000, 1'b0}, '{`ESF_OFF_SAMPLE_AT, 16'h0005, 10'h000, 1'b0},
		'{`ESF_OFF_GAIN_B0, 16'h0000, 10'h000, 1'b0}, '{`ESF_OFF_GAIN_B1, 16'h0003, 10'h000, 1'b0},
		'{`ESF_OFF_GAIN_B2, 16'h0001, 10'h000, 1'b0}, '{`ESF_OFF_LIGHT_THR, 16'h0064, 10'h000, 1'b0},
		'{`ESF_OFF_VOUT_CMD, 16'h03f0, 10'h3f0, 1'b0}, '{`ESF_OFF_CAL_OFF, 16'h0020, 10'h3ff, 1'b0},
		'{`ESF_OFF_VOUT_MAX, 16'h0300, 10'h300, 1'b0}, '{`ESF_OFF_VOUT_MAX, 16'h03ff, 10'h3ff, 1'b0},
		'{`ESF_OFF_CAL_OFF, 16'h03f0, 10'h3e0, 1'b0}, '{`ESF_OFF_VOUT_CMD, 16'h0100, 10'h0f0, 1'b0},
		'{`ESF_OFF_CAL_OFF, 16'h0000, 10'h100, 1'b0}, '{`ESF_OFF_MARGIN_HI, 16'h0200, 10'h100, 1'b0},
		'{`ESF_OFF_MARGIN_LO, 16'h0080, 10'h100, 1'b0}, '{`ESF_OFF_OPERATION, 16'h0020, 10'h200, 1'b0},
		'{`ESF_OFF_OPERATION, 16'h0010, 10'h080, 1'b0}, '{`ESF_OFF_OPERATION, 16'h0030, 10'h100, 1'b0},
		'{`ESF_OFF_OPERATION, 16'h0024, 10'h200, 1'b1}, '{`ESF_OFF_OPERATION, 16'h0004, 10'h100, 1'b0},
		'{`ESF_OFF_OPERATION, 16'h0000, 10'h100, 1'b0}};
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] reg_addr = 4'h0;
	logic [15:0] reg_wdata = 16'h0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [15:0] reg_rdata;
	logic [11:0] common_mv = 12'h200;
	logic [11:0] diff_mv = 12'h100;
	logic [11:0] pos_mv;
	logic [11:0] neg_mv;
	logic ramp_active = 1'b0;
	logic [15:0] out_current = 16'h00c8;
	logic [9:0] ref_dac_code;
	logic error_valid;
	logic error_ready = 1'b1;
	logic [5:0] error_code;
	logic [1:0] error_bank;
	logic error_saturated;
	logic fault_suppress;
	logic [15:0] rd_val;
	int fail_count = 0;
	int n_checks = 0;
	int cycles = 0;

	always #5 core_clk = ~core_clk;

	esf_sense_model i_sense (.core_clk(core_clk), .common_mv(common_mv), .diff_mv(diff_mv), .pos_mv(pos_mv),
		.neg_mv(neg_mv));

	esf_front_end #(.SENSE_W(12), .FIFO_DEPTH(4)) i_dut (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.sense_positive_input(pos_mv), .sense_negative_input(neg_mv), .ramp_active(ramp_active),
		.out_current(out_current), .ref_dac_code(ref_dac_code), .error_valid(error_valid),
		.error_ready(error_ready), .error_code(error_code), .error_bank(error_bank),
		.error_saturated(error_saturated), .fault_suppress(fault_suppress));

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic complete_run();
		if (fail_count == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic wait_clks(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask

	task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic reg_read(input logic [3:0] a);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		rd_val = reg_rdata;
	endtask

	// Stalls the consumer so the head conversion stands still, then checks it
	task automatic pop_check(input logic [5:0] code, input logic [1:0] bank);
		int k;
		k = 0;
		@(posedge core_clk);
		error_ready <= 1'b0;
		#1;
		while (error_valid !== 1'b1 && k < 100)
		begin
			wait_clks(1);
			k++;
		end
		check({10'h000, error_code}, {10'h000, code});
		check({14'h0000, error_bank}, {14'h0000, bank});
	endtask

	task automatic sat_phase(input logic [11:0] diff, input logic [1:0] flags);
		@(posedge core_clk);
		diff_mv <= diff;
		error_ready <= 1'b1;
		wait_clks(40);
		check({15'h0000, error_saturated}, {15'h0000, flags != 2'h0});
		reg_read(`ESF_OFF_STATUS);
		check(rd_val & 16'h0003, {14'h0000, flags});
	endtask

	always @(posedge core_clk)
	begin
		cycles++;
		if (cycles == 8000)
		begin
			fail_count++;
			complete_run();
		end
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		repeat (10) @(posedge core_clk);
		rst <= 1'b0;
		#1;
		check({6'h00, ref_dac_code}, 16'h0000);
		check({15'h0000, error_valid}, 16'h0000);
		reg_read(`ESF_OFF_VOUT_MAX);
		check(rd_val, 16'h03ff);
		reg_read(`ESF_OFF_SAMPLE_AT);
		check(rd_val, 16'h0032);
		reg_read(`ESF_OFF_PERIOD);
		check(rd_val, 16'h0064);
		wait_clks(1);
		check(reg_rdata, 16'h0000);
		reg_read(4'he);
		check(rd_val, 16'h0000);
		foreach (WRS[i])
		begin
			reg_write(WRS[i].addr, WRS[i].data);
			wait_clks(3);
			check({6'h00, ref_dac_code}, {6'h00, WRS[i].dac});
			check({15'h0000, fault_suppress}, {15'h0000, WRS[i].fs});
		end
		reg_write(`ESF_OFF_DAC, 16'h03ff);
		reg_read(`ESF_OFF_DAC);
		check(rd_val, 16'h0100);
		reg_read(`ESF_OFF_GAIN_B1);
		check(rd_val, 16'h0003);
		foreach (ROWS[i])
		begin
			@(posedge core_clk);
			ramp_active <= ROWS[i].ramp;
			out_current <= ROWS[i].cur;
			diff_mv <= ROWS[i].diff;
			error_ready <= 1'b1;
			wait_clks(45);
			pop_check(ROWS[i].code, ROWS[i].bank);
		end
		sat_phase(12'h0d8, 2'h1);
		check({6'h00, ref_dac_code}, 16'h0100);
		wait_clks(700);
		check({6'h00, ref_dac_code}, 16'h00ff);
		pop_check(6'h1f, 2'h1);
		sat_phase(12'h0ff, 2'h0);
		sat_phase(12'h128, 2'h2);
		wait_clks(700);
		check({6'h00, ref_dac_code}, 16'h0100);
		pop_check(6'h20, 2'h1);
		sat_phase(12'h100, 2'h0);
		@(posedge core_clk);
		error_ready <= 1'b0;
		wait_clks(160);
		reg_read(`ESF_OFF_STATUS);
		check(rd_val & 16'h0020, 16'h0020);
		@(posedge core_clk);
		error_ready <= 1'b1;
		#1;
		repeat (4)
		begin
			check({15'h0000, error_valid}, 16'h0001);
			check({10'h000, error_code}, 16'h0000);
			wait_clks(1);
		end
		// Reset in mid-run restores defaults and clears the stream
		@(posedge core_clk);
		rst <= 1'b1;
		repeat (3) @(posedge core_clk);
		rst <= 1'b0;
		#1;
		check({6'h00, ref_dac_code}, 16'h0000);
		check({15'h0000, error_valid}, 16'h0000);
		check({15'h0000, error_saturated}, 16'h0000);
		reg_read(`ESF_OFF_GAIN_B1);
		check(rd_val, 16'h0000);
		reg_read(`ESF_OFF_VOUT_CMD);
		check(rd_val, 16'h0000);
		complete_run();
	end
endmodule // testbench
